// ### core/orlp_exec.sv
// Decode and execute of the OR-with-file and pointer-load instructions
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module orlp_exec
    import orlp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Instruction stream, sampled during Q1
    input wire logic [15:0] instr_word,
    output logic word_sample,
    // Core state read by the block
    input wire logic [7:0] accum,
    input wire logic [3:0] bank_selector,
    // Data memory port, read data one cycle after the read strobe
    output orlp_mem_req_t mem,
    input wire logic [7:0] mem_rdata,
    // Writes into the core
    output logic accum_we,
    output logic [7:0] accum_wdata,
    output orlp_flag_t flags,
    output orlp_ptr_wr_t ptr,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);

    orlp_phase_t phase;
    orlp_op_t op, next_op;
    logic pend, next_pend;
    logic dest_file, next_dest_file;
    logic [11:0] lit, next_lit;
    logic [1:0] idx, next_idx;
    orlp_mem_req_t next_mem;
    logic next_accum_we;
    logic [7:0] next_accum_wdata;
    orlp_flag_t next_flags;
    orlp_ptr_wr_t next_ptr;
    logic [7:0] ctrl, next_ctrl;
    logic [7:0] next_reg_rdata;
    logic enable, sec_hit, or_hit, ptr_hit;
    logic [3:0] access_bank;
    logic [7:0] result;

    orlp_phase_gen i_orlp_phase_gen (
        .clk(clk),
        .sys_rst(sys_rst),
        .phase(phase)
    );

    assign word_sample = (phase == PH_Q1);
    assign enable = ctrl[CTRL_ENABLE_BIT];

    assign sec_hit = enable && pend && instr_word[15:8] == PTR_SECOND_PREFIX;
    assign or_hit = enable && !sec_hit && instr_word[15:10] == OR_PREFIX;
    // first word, index 3 is not a pointer
    assign ptr_hit = enable && !sec_hit && instr_word[15:6] == PTR_PREFIX
        && instr_word[5:4] != PTR_IDX_ILLEGAL;

    assign access_bank = instr_word[ACCESS_SPLIT_BIT] ? ACCESS_HIGH_BANK
                                                      : ACCESS_LOW_BANK;
    assign result = accum | mem_rdata;

    always_comb begin
        next_op = op;
        next_pend = pend;
        next_dest_file = dest_file;
        next_lit = lit;
        next_idx = idx;
        next_mem = mem;
        next_mem.rd = 1'b0;
        next_mem.wr = 1'b0;
        next_accum_we = 1'b0;
        next_accum_wdata = accum_wdata;
        next_flags = flags;
        next_flags.we = 1'b0;
        next_ptr = ptr;
        next_ptr.we_hi = 1'b0;
        next_ptr.we_lo = 1'b0;
        unique case (phase)
            PH_Q1: begin
                // A missing second word drops the pending pointer load
                next_pend = 1'b0;
                next_op = OP_NONE;
                if (sec_hit) begin
                    next_op = OP_PTR_LO;
                    next_lit[7:0] = instr_word[7:0];
                end else if (or_hit) begin
                    next_op = OP_OR;
                    next_dest_file = instr_word[DEST_BIT];
                    next_mem.rd = 1'b1;
                    next_mem.addr[7:0] = instr_word[7:0];
                    if (instr_word[BANK_BIT]) begin
                        next_mem.addr[11:8] = bank_selector;
                    end else begin
                        next_mem.addr[11:8] = access_bank;
                    end
                end else if (ptr_hit) begin
                    next_op = OP_PTR_HI;
                    next_idx = instr_word[PTR_IDX_LSB +: 2];
                    next_lit[11:8] = instr_word[3:0];
                end
            end
            PH_Q2: begin
            end
            PH_Q3: begin
                if (op == OP_OR) begin
                    next_accum_we = !dest_file;
                    next_mem.wr = dest_file;
                    next_accum_wdata = result;
                    next_mem.wdata = result;
                    next_flags.we = 1'b1;
                    next_flags.neg = result[NEG_BIT];
                    next_flags.zero = (result == 8'h00);
                end else if (op == OP_PTR_HI) begin
                    next_ptr.we_hi = 1'b1;
                    next_ptr.sel = idx;
                    next_ptr.data = {4'h0, lit[11:8]};
                    next_pend = 1'b1;
                end else if (op == OP_PTR_LO) begin
                    next_ptr.we_lo = 1'b1;
                    next_ptr.sel = idx;
                    next_ptr.data = lit[7:0];
                end
            end
            PH_Q4: begin
                next_op = OP_NONE;
            end
        endcase
    end

    always_comb begin
        next_ctrl = ctrl;
        next_reg_rdata = 8'h00;
        if (reg_wr && reg_addr == REG_CTRL) begin
            next_ctrl = reg_wdata;
        end
        if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                next_reg_rdata = ctrl;
            end else if (reg_addr == REG_STATUS) begin
                next_reg_rdata[STATUS_PEND_BIT] = pend;
                next_reg_rdata[STATUS_PHASE_LSB +: 2] = phase;
                next_reg_rdata[STATUS_OP_LSB +: 2] = op;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            op <= OP_NONE;
            pend <= 1'b0;
            dest_file <= 1'b1;
            lit <= 12'h000;
            idx <= 2'h0;
            mem <= '0;
            accum_we <= 1'b0;
            accum_wdata <= 8'h00;
            flags <= '0;
            ptr <= '0;
            ctrl <= CTRL_RESET;
            reg_rdata <= 8'h00;
        end else begin
            op <= next_op;
            pend <= next_pend;
            dest_file <= next_dest_file;
            lit <= next_lit;
            idx <= next_idx;
            mem <= next_mem;
            accum_we <= next_accum_we;
            accum_wdata <= next_accum_wdata;
            flags <= next_flags;
            ptr <= next_ptr;
            ctrl <= next_ctrl;
            reg_rdata <= next_reg_rdata;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    AST_OR_RESULT: assert property (
        accum_we || mem.wr |-> accum_wdata == ($past(accum) | $past(mem_rdata))
            && flags.we && flags.zero == (accum_wdata == 8'h00)
            && flags.neg == accum_wdata[7])
        else $error("OR result or flags wrong");

    AST_OR_DECODE: assert property (
        phase == PH_Q1 && enable && !pend && instr_word[15:10] == 6'h04
            |=> op == OP_OR && mem.rd)
        else $error("OR opcode not decoded");

    AST_DEST_ACCUM: assert property (
        phase == PH_Q1 && or_hit && !instr_word[9]
            |-> ##3 accum_we && !mem.wr)
        else $error("accumulator destination missed");

    AST_DEST_FILE: assert property (
        phase == PH_Q1 && or_hit && instr_word[9]
            |-> ##3 mem.wr && !accum_we
            && mem.addr == $past(mem.addr, 2))
        else $error("file destination missed");

    AST_ACCESS_BANK: assert property (
        phase == PH_Q1 && or_hit && !instr_word[8]
            |=> mem.addr[7:0] == $past(instr_word[7:0])
            && mem.addr[11:8] == ($past(instr_word[7]) ? 4'hf : 4'h0))
        else $error("access bank address wrong");

    AST_BANKED: assert property (
        phase == PH_Q1 && or_hit && instr_word[8]
            |=> mem.addr == {$past(bank_selector), $past(instr_word[7:0])})
        else $error("banked address wrong");

    AST_PTR_NO_FLAGS: assert property (
        ptr.we_hi || ptr.we_lo |-> !flags.we && !accum_we && !mem.wr
            && ptr.sel != 2'h3)
        else $error("pointer load touched flags");

    AST_PTR_HI: assert property (
        phase == PH_Q1 && enable && !pend && instr_word[15:6] == 10'h3b8
            && instr_word[5:4] != 2'h3
            |-> ##3 ptr.we_hi && ptr.sel == $past(instr_word[5:4], 3)
            && ptr.data == {4'h0, $past(instr_word[3:0], 3)})
        else $error("pointer high byte wrong");

    AST_PTR_LO: assert property (
        phase == PH_Q1 && enable && pend && instr_word[15:8] == 8'hf0
            |-> ##3 ptr.we_lo && ptr.data == $past(instr_word[7:0], 3))
        else $error("pointer low byte wrong");

    AST_OR_ONE_CYCLE: assert property (
        phase == PH_Q1 && or_hit
            |-> ##1 mem.rd ##1 !mem.rd ##1 (mem.wr || accum_we)
            ##1 !mem.wr && !accum_we && phase == PH_Q1)
        else $error("OR timing wrong");

    AST_PTR_TWO_CYCLE: assert property (
        ptr.we_hi |=> pend && !ptr.we_lo
            ##1 (!pend && !ptr.we_lo && !ptr.we_hi) [*2]
            ##1 !(ptr.we_hi && ptr.we_lo))
        else $error("pointer load sequencing wrong");

    COV_OR_ACCUM: cover property (accum_we);
    COV_OR_FILE: cover property (mem.wr);
    COV_PTR_FULL: cover property (ptr.we_hi ##4 ptr.we_lo);

endmodule

// ### core/orlp_pkg.sv
// Shared constants and carrier types for the OR / pointer-load executor
package orlp_pkg;

    // Instruction phases within one instruction cycle
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } orlp_phase_t;

    // Operation held between phases
    typedef enum logic [1:0] {
        OP_NONE   = 2'b00,
        OP_OR     = 2'b01,
        OP_PTR_HI = 2'b10,
        OP_PTR_LO = 2'b11
    } orlp_op_t;

    // Opcode prefixes and field positions
    localparam logic [5:0] OR_PREFIX = 6'h04;
    localparam logic [9:0] PTR_PREFIX = 10'h3b8;
    localparam logic [7:0] PTR_SECOND_PREFIX = 8'hf0;
    localparam logic [1:0] PTR_IDX_ILLEGAL = 2'h3;
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;
    localparam int PTR_IDX_LSB = 4;
    localparam int NEG_BIT = 7;

    // Access bank layout: low half in bank 0, high half in the top bank
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam int ACCESS_SPLIT_BIT = 7;

    // Control and status registers
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam int STATUS_PEND_BIT = 0;
    localparam int STATUS_PHASE_LSB = 1;
    localparam int STATUS_OP_LSB = 3;

    typedef struct packed {
        logic [11:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } orlp_mem_req_t;

    typedef struct packed {
        logic we_hi;
        logic we_lo;
        logic [1:0] sel;
        logic [7:0] data;
    } orlp_ptr_wr_t;

    typedef struct packed {
        logic we;
        logic neg;
        logic zero;
    } orlp_flag_t;

endpackage

// ### core/orlp_phase_gen.sv
// Four-phase sequencer that splits the instruction cycle into Q1..Q4
`timescale 1ns/10ps
module orlp_phase_gen
    import orlp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Current phase
    output orlp_phase_t phase
);

    orlp_phase_t next_phase;

    always_comb begin
        unique case (phase)
            PH_Q1: next_phase = PH_Q2;
            PH_Q2: next_phase = PH_Q3;
            PH_Q3: next_phase = PH_Q4;
            PH_Q4: next_phase = PH_Q1;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= PH_Q1;
        end else begin
            phase <= next_phase;
        end
    end

endmodule

// ### verification/orlp_exec_tb_top.sv
// Self-checking bench for the OR and pointer-load executor
`timescale 1ns/10ps
`define CHK(n, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            err_total++; \
            $display("mismatch %s expected %h seen %h", n, e, g); \
        end \
    end
module orlp_exec_tb_top
    import orlp_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] instr_word = 16'h0000;
    logic word_sample;
    logic [7:0] accum = 8'h00;
    logic [3:0] bank_selector = 4'h0;
    orlp_mem_req_t mem;
    logic [7:0] mem_rdata = 8'h00;
    logic accum_we;
    logic [7:0] accum_wdata;
    orlp_flag_t flags;
    orlp_ptr_wr_t ptr;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    int err_total = 0;
    int comparisons = 0;

    orlp_exec i_orlp_exec (
        .clk(clk), .sys_rst(sys_rst), .instr_word(instr_word),
        .word_sample(word_sample), .accum(accum),
        .bank_selector(bank_selector), .mem(mem), .mem_rdata(mem_rdata),
        .accum_we(accum_we), .accum_wdata(accum_wdata), .flags(flags),
        .ptr(ptr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    initial begin
        forever #2 clk = ~clk;
    end

    task stop_test;
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task reg_write(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task reg_read(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", exp, reg_rdata)
        @(posedge clk);
    endtask

    // Ends on the edge that opens a Q1 cycle
    task align;
        do @(negedge clk); while (word_sample !== 1'b1);
        repeat (4) @(posedge clk);
    endtask

    task do_or(input logic [15:0] w, input logic [7:0] acc,
               input logic [3:0] bsel, input logic [7:0] fd);
        logic [7:0] res;
        logic [11:0] ea;
        res = acc | fd;
        // Access bank: low half in bank 0, high half in bank f
        ea = w[8] ? {bsel, w[7:0]} : {{4{w[7]}}, w[7:0]};
        instr_word <= w;
        accum <= acc;
        bank_selector <= bsel;
        #1;
        `CHK("word_sample", 1'b1, word_sample)
        @(posedge clk);
        #1;
        `CHK("mem_rd", 1'b1, mem.rd)
        `CHK("mem_addr", ea, mem.addr)
        @(posedge clk);
        mem_rdata <= fd;
        @(posedge clk);
        #1;
        `CHK("mem_wr", w[9], mem.wr)
        `CHK("accum_we", ~w[9], accum_we)
        `CHK("result", res, w[9] ? mem.wdata : accum_wdata)
        `CHK("flag_we", 1'b1, flags.we)
        `CHK("neg", res[7], flags.neg)
        `CHK("zero", res == 8'h00, flags.zero)
        `CHK("ptr_we", 2'b00, {ptr.we_hi, ptr.we_lo})
        @(posedge clk);
        mem_rdata <= ~fd;
    endtask

    task do_ptr(input logic [1:0] idx, input logic [11:0] k,
                input bit second);
        instr_word <= {10'b1110111000, idx, k[11:8]};
        repeat (3) @(posedge clk);
        #1;
        `CHK("we_hi", 2'b10, {ptr.we_hi, ptr.we_lo})
        `CHK("sel_hi", idx, ptr.sel)
        `CHK("data_hi", {4'h0, k[11:8]}, ptr.data)
        `CHK("flag_hi", 1'b0, flags.we)
        @(posedge clk);
        if (second) begin
            instr_word <= {8'b11110000, k[7:0]};
            repeat (3) @(posedge clk);
            #1;
            `CHK("we_lo", 2'b01, {ptr.we_hi, ptr.we_lo})
            `CHK("sel_lo", idx, ptr.sel)
            `CHK("data_lo", k[7:0], ptr.data)
            `CHK("flag_lo", 1'b0, flags.we)
            @(posedge clk);
        end
    endtask

    // A refused word leaves every strobe low
    task nop_chk(input logic [15:0] w);
        instr_word <= w;
        @(posedge clk);
        #1;
        `CHK("rd_off", 1'b0, mem.rd)
        repeat (2) @(posedge clk);
        #1;
        `CHK("wr_off", 5'h00, {mem.wr, accum_we, flags.we, ptr.we_hi,
            ptr.we_lo})
        @(posedge clk);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        reg_read(4'h0, 8'h01);
        reg_write(4'h7, 8'hff);
        reg_read(4'h7, 8'h00);
        align;
        do_or(16'h1125, 8'h91, 4'h3, 8'h13);
        do_or(16'h1240, 8'h00, 4'h3, 8'h00);
        do_or(16'h12c5, 8'h80, 4'h3, 8'h01);
        do_or(16'h13ff, 8'h0f, 4'ha, 8'h30);
        do_ptr(2'd0, 12'h000, 1'b1);
        do_ptr(2'd1, 12'hfff, 1'b1);
        do_ptr(2'd2, 12'h3ab, 1'b1);
        do_ptr(2'd1, 12'h5a6, 1'b0);
        do_or(16'h1010, 8'h22, 4'h1, 8'h44);
        nop_chk({10'b1110111000, 2'd3, 4'h7});
        nop_chk(16'hf012);
        nop_chk(16'h0935);
        nop_chk(16'h1400);
        reg_write(4'h0, 8'h00);
        reg_read(4'h0, 8'h00);
        align;
        nop_chk(16'h1125);
        reg_write(4'h0, 8'h01);
        align;
        do_or(16'h1301, 8'h5a, 4'h0, 8'ha5);
        // Status read in Q2 of the repeated OR word: op OR, phase Q2
        @(posedge clk);
        reg_read(REG_STATUS, 8'h0a);
        stop_test;
    end

    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        stop_test;
    end
endmodule
